// >>> rtl/sasq_defines.svh
// Purpose: Register offsets, field positions and reset values of the
//          scan acquisition sequencer.
// Assumes: Byte addresses on an AXI4-Lite bus, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef SASQ_DEFINES_SVH
`define SASQ_DEFINES_SVH

// Register byte offsets
`define SASQ_REG_CTRL 8'h00
`define SASQ_REG_START 8'h04
`define SASQ_REG_CLEAR 8'h08
`define SASQ_REG_SCANLD 8'h0C
`define SASQ_REG_STATUS 8'h10
`define SASQ_REG_FIFO 8'h14
`define SASQ_REG_SCANWR 8'h18
`define SASQ_REG_SCANCLR 8'h1C
`define SASQ_REG_CNTLO 8'h20
`define SASQ_REG_CNTHI 8'h24
`define SASQ_REG_LAST 8'h24

// Control register fields
`define SASQ_CTRL_ACQ_EN 0
`define SASQ_CTRL_SCAN_EN 1
`define SASQ_CTRL_CNT32 2
`define SASQ_CTRL_INTERNAL_GATE_N_N 3
`define SASQ_CTRL_SCAN_STEP_DIVIDER 4
`define SASQ_CTRL_EXTERNAL_CONVERT_N 5
`define SASQ_CTRL_WIDTH 6
`define SASQ_CTRL_RESET 6'h08

// Status register fields
`define SASQ_STAT_HAS_DATA 0
`define SASQ_STAT_OVERRUN_N 1
`define SASQ_STAT_OVERFLOW_N 2
`define SASQ_STAT_RUNNING 3
`define SASQ_STAT_ARMED 4
`define SASQ_STAT_COUNT_DONE 5

// Scan entry layout
`define SASQ_ENTRY_END 8

// Pin positions in the synchronised pin vector
`define SASQ_PIN_INTERVAL 0
`define SASQ_PIN_EXTERNAL_CONVERT_N 1
`define SASQ_PIN_TRIG 2
`define SASQ_PIN_GATE 3
`define SASQ_PIN_DIV 4
`define SASQ_PIN_COUNT 5

// Bus responses
`define SASQ_RESP_OKAY 2'h0
`define SASQ_RESP_SLVERR 2'h2

`endif

// >>> rtl/sasq_pkg.sv
// Purpose: Types shared by the scan acquisition sequencer.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in sasq_defines.svh.
package sasq_pkg;
    // Run sequencing states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN,
        ST_STOP
    } sasq_state_t;
endpackage

// >>> rtl/sasq_sample_counter.sv
// Purpose: Sample counter, low half alone or low and high halves cascaded.
// Assumes: tick is a one-cycle pulse on clk_sys, one per conversion.
// Notes:   A load wins over a tick in the same cycle.
module sasq_sample_counter (
    input wire logic clk_sys,
    input wire logic rstN,
    input wire logic loadLow,
    input wire logic loadHigh,
    input wire logic [15:0] loadValue,
    input wire logic cascade,
    input wire logic tick,
    output logic [15:0] lowCount,
    output logic [15:0] highCount,
    output logic lastCount
);
    import sasq_pkg::*;

    logic [15:0] next_lowCount;
    logic [15:0] next_highCount;

    // Which tick ends the count in each width
    always_comb begin
        if (cascade) begin
            lastCount = (lowCount == 16'h0000) && (highCount == 16'h0000); // R11
        end else begin
            lastCount = (lowCount == 16'h0001); // R4 R3
        end
    end

    // Load, or step down; when cascaded, the high half steps as the low half reaches zero
    always_comb begin
        next_lowCount = lowCount;
        next_highCount = highCount;
        if (loadLow || loadHigh) begin
            if (loadLow) begin
                next_lowCount = loadValue;
            end
            if (loadHigh) begin
                next_highCount = loadValue;
            end
        end else if (tick) begin
            next_lowCount = lowCount - 16'h0001; // R4
            if (cascade && lowCount == 16'h0001) begin
                next_highCount = highCount - 16'h0001; // R11 R10
            end
        end
    end

    // Counter registers
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            lowCount <= 16'h0000;
            highCount <= 16'h0000;
        end else begin
            lowCount <= next_lowCount;
            highCount <= next_highCount;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstN);

    AST_HIGH_STEP: assert property ( // R11
        !loadLow && !loadHigh && tick && cascade && lowCount == 16'h0001
        |=> highCount == $past(highCount) - 16'h0001 && lowCount == 16'h0000)
        else $error("high half did not step as low half reached zero");
endmodule

// >>> rtl/sasq_scan_sequencer.sv
// Purpose: Posttrigger scanning acquisition sequencer with AXI4-Lite access.
// Assumes: ADC handshake on clk_sys; pins are asynchronous and active low.
// Notes:   Pins pass two flip-flops; reset is released through two more.
// Summary of operation
// R1: Host never loads fewer than 2 samples; 65,536 is loaded as 0.
// R2: Host sets low counter mode and load value, then loads and arms it.
// R3: Count-width bit clear makes the low counter alone the sample counter.
// R4: Single width: each conversion steps low counter; run ends at zero. With scanning the code runs on to the scan-end entry.
// R5: Above 65,536 the count splits into low and high 16-bit halves.
// R6: Cascaded low half is loaded minus one, all ones when zero.
// R7: Cascaded low reload value is zero; host then arms the counter.
// R8: Host sets high counter mode and selects its load register.
// R9: High half gets upper bits, plus one unless lower bits are 0 or 1.
// R10: Host loads and arms high half, then sets the count-width bit.
// R11: Cascaded: high steps at low zero; end needs both zero, last entry.
// R12: Host picks a count that is a multiple of the scan length.
// R13: Clear write empties the FIFO; scan-load write selects first entry.
// R14: Host sets acquisition and scan enables with both gates disabled.
// R15: Software start write triggers unless the trigger pin is held low.
// R16: A low pulse on the trigger pin starts an armed run.
// R17: After the trigger the interval counter is gated until count ends. With scanning the code gates on to the scan-end entry.
// R18: Overrun or overflow halts the run; host clears and investigates.
// R19: Host polls status and reads one result while data is present.
// R20: External mode: interval counter idle, falling strobe edges convert.
// R21: External mode: strobes are ignored until a start or trigger.
// R22: External mode: conversions stop at zero count despite strobes. With scanning the code converts on to the scan-end entry.
// R23: Scan-end entry closes the sequence, which restarts from entry one.
// R24: Scan step per conversion, or per divider pulse when divider set.
`include "sasq_defines.svh"

module sasq_scan_sequencer #(
    parameter int FIFO_DEPTH = 16,
    parameter int SCAN_DEPTH = 16,
    parameter int DATA_WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic intervalPulseN,
    input wire logic externalConvertN,
    input wire logic externalTriggerN,
    input wire logic externalGateN,
    input wire logic dividerPulseN,
    input wire logic adcBusy,
    input wire logic adcDone,
    input wire logic [DATA_WIDTH-1:0] adcData,
    output logic convertStart,
    output logic intervalGate,
    output logic [7:0] muxSelect
);
    import sasq_pkg::*;

    localparam int FAW = $clog2(FIFO_DEPTH);
    localparam int SAW = $clog2(SCAN_DEPTH);

    logic [1:0] rstPipe;
    logic rstN;
    logic [`SASQ_PIN_COUNT-1:0] pinMeta, pinSync, pinPrev, pinFall;
    logic awHeld, wHeld, next_awHeld, next_wHeld;
    logic [7:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata, rdValue;
    logic wrFire, wrCtrl, wrStart, wrClear, wrScanLd, wrScanWr, wrScanClr;
    logic wrCntLo, wrCntHi, popFifo;
    sasq_state_t state, next_state;
    logic [`SASQ_CTRL_WIDTH-1:0] ctrl, next_ctrl;
    logic overrunN, overflowN, countDone;
    logic next_overrunN, next_overflowN, next_countDone;
    logic next_convertStart, next_intervalGate;
    logic [SAW-1:0] rdPtr, wrPtr, next_rdPtr, next_wrPtr;
    logic [FAW-1:0] fifoRd, fifoWr, next_fifoRd, next_fifoWr;
    logic [FAW:0] fifoCnt, next_fifoCnt;
    logic [8:0] scanMem [SCAN_DEPTH];
    logic [DATA_WIDTH-1:0] fifoMem [FIFO_DEPTH];
    logic fifoFull, fifoEmpty, pushFifo, overflowEv, overrunEv;
    logic extMode, scan_enable, gateBlock, convFall, convReq, convAccept;
    logic trigger, tick, lastCount, entryEnd, endNow, stepScan;
    logic [15:0] lowCount, highCount;

    // Reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    // Two-stage pin synchronisers and a delayed copy for edge detection
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            pinMeta <= 5'h1F;
            pinSync <= 5'h1F;
            pinPrev <= 5'h1F;
        end else begin
            pinMeta <= {dividerPulseN, externalGateN, externalTriggerN,
                        externalConvertN, intervalPulseN};
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end
    assign pinFall = pinPrev & ~pinSync;

    // Bus handshakes: one write and one read under way at a time
    assign s_axi_awready = !awHeld;
    assign s_axi_wready = !wHeld;
    assign s_axi_arready = !s_axi_rvalid;
    assign wrFire = awHeld && wHeld && !s_axi_bvalid;

    // Write decode, performed once both address and data are held
    always_comb begin
        wrCtrl = wrFire && awAddr == `SASQ_REG_CTRL && wStrb[0];
        wrStart = wrFire && awAddr == `SASQ_REG_START;
        wrClear = wrFire && awAddr == `SASQ_REG_CLEAR;
        wrScanLd = wrFire && awAddr == `SASQ_REG_SCANLD;
        wrScanWr = wrFire && awAddr == `SASQ_REG_SCANWR && wStrb[1:0] == 2'h3;
        wrScanClr = wrFire && awAddr == `SASQ_REG_SCANCLR;
        wrCntLo = wrFire && awAddr == `SASQ_REG_CNTLO && wStrb[1:0] == 2'h3;
        wrCntHi = wrFire && awAddr == `SASQ_REG_CNTHI && wStrb[1:0] == 2'h3;
        popFifo = s_axi_arvalid && s_axi_arready && !fifoEmpty
                  && s_axi_araddr == `SASQ_REG_FIFO;
    end

    // Read data multiplexer
    always_comb begin
        rdValue = 32'h0000_0000;
        unique case (s_axi_araddr)
            `SASQ_REG_CTRL: rdValue[`SASQ_CTRL_WIDTH-1:0] = ctrl;
            `SASQ_REG_STATUS: rdValue[5:0] = {countDone, state == ST_ARMED,
                state == ST_RUN, overflowN, overrunN, !fifoEmpty};
            `SASQ_REG_FIFO: rdValue[DATA_WIDTH-1:0] = fifoMem[fifoRd];
            `SASQ_REG_CNTLO: rdValue[15:0] = lowCount;
            `SASQ_REG_CNTHI: rdValue[15:0] = highCount;
            default: rdValue = 32'h0000_0000;
        endcase
    end

    // Bus channel next values
    always_comb begin
        next_awHeld = awHeld;
        next_awAddr = awAddr;
        next_wHeld = wHeld;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wrFire) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (awAddr[1:0] == 2'h0 && awAddr <= `SASQ_REG_LAST)
                         ? `SASQ_RESP_OKAY : `SASQ_RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata = rdValue;
            next_rresp = (s_axi_araddr[1:0] == 2'h0
                          && s_axi_araddr <= `SASQ_REG_LAST)
                         ? `SASQ_RESP_OKAY : `SASQ_RESP_SLVERR;
        end
    end

    // Bus channel registers
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            awHeld <= 1'b0;
            awAddr <= 8'h00;
            wHeld <= 1'b0;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SASQ_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SASQ_RESP_OKAY;
        end else begin
            awHeld <= next_awHeld;
            awAddr <= next_awAddr;
            wHeld <= next_wHeld;
            wData <= next_wData;
            wStrb <= next_wStrb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // Conversion requests, gating and triggers
    always_comb begin
        extMode = ctrl[`SASQ_CTRL_EXTERNAL_CONVERT_N];
        scan_enable = ctrl[`SASQ_CTRL_SCAN_EN];
        gateBlock = !ctrl[`SASQ_CTRL_INTERNAL_GATE_N_N] && !pinSync[`SASQ_PIN_GATE];
        convFall = extMode ? pinFall[`SASQ_PIN_EXTERNAL_CONVERT_N] // R20
                           : pinFall[`SASQ_PIN_INTERVAL]; // R17
        convReq = state == ST_RUN && convFall && !gateBlock; // R21
        convAccept = convReq && !adcBusy && !convertStart;
        overrunEv = convReq && !convAccept;
        tick = convAccept && !countDone;
        entryEnd = scanMem[rdPtr][`SASQ_ENTRY_END];
        endNow = convAccept && (countDone || (tick && lastCount)) // R22
                 && (entryEnd || !scan_enable); // R11
        trigger = (wrStart && pinSync[`SASQ_PIN_TRIG]) // R15
                  || pinFall[`SASQ_PIN_TRIG]; // R16
        stepScan = state == ST_RUN && scan_enable
                   && (ctrl[`SASQ_CTRL_SCAN_STEP_DIVIDER] ? pinFall[`SASQ_PIN_DIV]
                                                : convAccept); // R24
        fifoFull = fifoCnt == (FAW+1)'(FIFO_DEPTH);
        fifoEmpty = fifoCnt == '0;
        pushFifo = adcDone && !fifoFull;
        overflowEv = adcDone && fifoFull;
    end

    // Run sequencing, error flags, FIFO and scan pointers
    always_comb begin
        next_state = state;
        next_ctrl = wrCtrl ? wData[`SASQ_CTRL_WIDTH-1:0] : ctrl;
        next_countDone = countDone || (tick && lastCount);
        next_overrunN = wrClear ? 1'b1 : overrunN;
        next_overflowN = wrClear ? 1'b1 : overflowN;
        if (overrunEv) begin
            next_overrunN = 1'b0; // R18
        end
        if (overflowEv) begin
            next_overflowN = 1'b0; // R18
        end
        unique case (state)
            ST_IDLE: if (ctrl[`SASQ_CTRL_ACQ_EN]) next_state = ST_ARMED;
            ST_ARMED: if (trigger) next_state = ST_RUN; // R15 R16 R21
            ST_RUN: begin
                if (overrunEv || overflowEv || !overrunN || !overflowN) begin
                    next_state = ST_STOP; // R18
                end else if (endNow) begin
                    next_state = ST_STOP; // R4 R11 R22
                end
            end
            ST_STOP: next_state = ST_STOP;
        endcase
        if (!ctrl[`SASQ_CTRL_ACQ_EN]) begin
            next_state = ST_IDLE;
        end else if (wrClear) begin
            next_state = ST_ARMED;
        end
        if (next_state == ST_ARMED && state != ST_ARMED) begin
            next_countDone = 1'b0;
        end
        next_fifoWr = pushFifo ? fifoWr + 1'b1 : fifoWr;
        next_fifoRd = popFifo ? fifoRd + 1'b1 : fifoRd;
        next_fifoCnt = fifoCnt + (FAW+1)'(pushFifo) - (FAW+1)'(popFifo);
        if (wrClear) begin
            next_fifoWr = '0; // R13
            next_fifoRd = '0;
            next_fifoCnt = '0;
        end
        next_rdPtr = rdPtr;
        if (wrScanLd) begin
            next_rdPtr = '0; // R13
        end else if (stepScan) begin
            next_rdPtr = (entryEnd || rdPtr == SAW'(SCAN_DEPTH-1))
                         ? '0 : rdPtr + 1'b1; // R23
        end
        next_wrPtr = wrScanClr ? '0 : (wrScanWr ? wrPtr + 1'b1 : wrPtr);
        next_convertStart = convAccept; // R17 R20
        next_intervalGate = next_state == ST_RUN
                            && !next_ctrl[`SASQ_CTRL_EXTERNAL_CONVERT_N]; // R17 R20
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            state <= ST_IDLE;
            ctrl <= `SASQ_CTRL_RESET;
            countDone <= 1'b0;
            overrunN <= 1'b1;
            overflowN <= 1'b1;
            fifoWr <= '0;
            fifoRd <= '0;
            fifoCnt <= '0;
            rdPtr <= '0;
            wrPtr <= '0;
            convertStart <= 1'b0;
            intervalGate <= 1'b0;
            muxSelect <= 8'h00;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            countDone <= next_countDone;
            overrunN <= next_overrunN;
            overflowN <= next_overflowN;
            fifoWr <= next_fifoWr;
            fifoRd <= next_fifoRd;
            fifoCnt <= next_fifoCnt;
            rdPtr <= next_rdPtr;
            wrPtr <= next_wrPtr;
            convertStart <= next_convertStart;
            intervalGate <= next_intervalGate;
            muxSelect <= scanMem[next_rdPtr][7:0];
        end
    end

    // Scan entry and result storage
    always_ff @(posedge clk_sys) begin
        if (wrScanWr) begin
            scanMem[wrPtr] <= wData[8:0];
        end
        if (pushFifo) begin
            fifoMem[fifoWr] <= adcData;
        end
    end

    sasq_sample_counter u_counter (
        .clk_sys(clk_sys),
        .rstN(rstN),
        .loadLow(wrCntLo),
        .loadHigh(wrCntHi),
        .loadValue(wData[15:0]),
        .cascade(ctrl[`SASQ_CTRL_CNT32]), // R3 R10
        .tick(tick),
        .lowCount(lowCount),
        .highCount(highCount),
        .lastCount(lastCount)
    );

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstN);

    AST_CONV_IN_RUN: assert property ( // R17
        convertStart |-> $past(state) == ST_RUN)
        else $error("conversion started outside a run");
    AST_ARMED_IGNORES: assert property ( // R21
        state == ST_ARMED |=> !convertStart)
        else $error("strobe converted before trigger");
    AST_HALT_ON_ERROR: assert property ( // R18
        state == ST_RUN && overrunEv |=> !overrunN ##1 state != ST_RUN)
        else $error("run not halted after overrun");
    AST_STOP_SILENT: assert property ( // R22
        state == ST_STOP && $past(state) == ST_STOP |-> !convertStart[*2])
        else $error("conversion after count end");
    AST_SW_START: assert property ( // R15
        state == ST_ARMED && wrStart && pinSync[`SASQ_PIN_TRIG]
        && ctrl[`SASQ_CTRL_ACQ_EN] && !wrClear |=> state == ST_RUN)
        else $error("software start ignored");
    AST_PIN_TRIGGER: assert property ( // R16
        state == ST_ARMED && $fell(pinSync[`SASQ_PIN_TRIG])
        && ctrl[`SASQ_CTRL_ACQ_EN] |=> state == ST_RUN)
        else $error("trigger pin pulse ignored");
    AST_SCAN_WRAP: assert property ( // R23
        stepScan && entryEnd && !wrScanLd |=> rdPtr == '0)
        else $error("scan did not restart after end marker");
    AST_SCAN_STEP: assert property ( // R24
        stepScan && !entryEnd && !wrScanLd
        && rdPtr != SAW'(SCAN_DEPTH-1) |=> rdPtr == $past(rdPtr) + 1'b1)
        else $error("scan entry did not advance");
    AST_GATE_RUN: assert property ( // R20
        intervalGate |-> state == ST_RUN && !extMode)
        else $error("interval counter gated outside internal run");
    AST_CLEAR_EMPTY: assert property ( // R13
        wrClear && !overrunEv && !overflowEv
        |=> fifoEmpty && overrunN && overflowN)
        else $error("clear did not empty the FIFO");
endmodule

// >>> tb/sasq_adc_model.sv
// Purpose: ADC stand-in that answers each conversion start pulse.
// Assumes: One conversion at a time, busy for four cycles.
// Notes:   Results count up from A000 so their order is visible.
module sasq_adc_model (
    input wire logic clk_sys,
    input wire logic convertStart,
    output logic adcBusy,
    output logic adcDone,
    output logic [15:0] adcData
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] left = 3'h0;
    logic [15:0] seq = 16'hA000;
    // Busy timer; data is only held in the done cycle, else it toggles
    always @(posedge clk_sys) begin
        adcDone <= 1'h0;
        adcData <= ~adcData;
        if (convertStart === 1'h1) begin
            left <= 3'h4;
        end else if (left != 3'h0) begin
            left <= left - 3'h1;
            if (left == 3'h1) begin
                adcDone <= 1'h1;
                adcData <= seq;
                seq <= seq + 16'h1;
            end
        end
    end
    assign adcBusy = (left != 3'h0);
endmodule

// >>> tb/scan_acquisition_sequencer_tb_top.sv
// Purpose: Self-checking bench for the scan acquisition sequencer.
// Assumes: Interval, strobe and trigger pins are pulsed from here.
// Notes:   Registers are reached through AXI4-Lite tasks.
`include "sasq_defines.svh"
module scan_acquisition_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'h0;
    logic arst_n = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [4:0] pinN = 5'h1F;
    logic adcBusy, adcDone, convertStart, intervalGate;
    logic [15:0] adcData;
    logic [7:0] muxSelect;
    logic [7:0] entry [3] = '{8'h11, 8'h22, 8'h33};
    int bad_count = 0, num_checks = 0, convs = 0;

    sasq_scan_sequencer u_sasq_scan_sequencer (
        .clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .intervalPulseN(pinN[0]),
        .externalConvertN(pinN[1]), .externalTriggerN(pinN[2]),
        .externalGateN(pinN[3]), .dividerPulseN(pinN[4]), .adcBusy,
        .adcDone, .adcData, .convertStart, .intervalGate, .muxSelect
    );
    sasq_adc_model u_sasq_adc_model (
        .clk_sys, .convertStart, .adcBusy, .adcDone, .adcData
    );

    // System clock
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // Conversion tally
    always @(posedge clk_sys) begin
        if (convertStart === 1'h1) convs <= convs + 1;
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        chk("rdata", e, s_axi_rdata & m);
    endtask
    // Low pulse on one pin, then time for the conversion to finish
    task automatic pulse(input int k);
        @(posedge clk_sys);
        pinN[k] <= 1'h0;
        repeat (3) @(posedge clk_sys);
        pinN[k] <= 1'h1;
        repeat (12) @(posedge clk_sys);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'h1;
        repeat (4) @(posedge clk_sys);
        rd(`SASQ_REG_CTRL, 32'hFF, 32'h08, `SASQ_RESP_OKAY);
        rd(`SASQ_REG_STATUS, 32'h7, 32'h6, `SASQ_RESP_OKAY);
        rd(8'h28, 32'hFFFFFFFF, 32'h0, `SASQ_RESP_SLVERR);
        wr(8'h30, 32'h0, `SASQ_RESP_SLVERR);
        // Three-entry scan, six samples, single width, internal pacing
        wr(`SASQ_REG_SCANCLR, 32'h0, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_SCANWR, 32'h11, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_SCANWR, 32'h22, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_SCANWR, 32'h133, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_CNTLO, 32'h6, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_CTRL, 32'h08, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_CLEAR, 32'h0, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_SCANLD, 32'h0, `SASQ_RESP_OKAY);
        rd(`SASQ_REG_CNTLO, 32'hFFFF, 32'h6, `SASQ_RESP_OKAY);
        chk("mux", 32'h11, {24'h0, muxSelect});
        wr(`SASQ_REG_CTRL, 32'h0B, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_START, 32'h0, `SASQ_RESP_OKAY);
        repeat (6) @(posedge clk_sys);
        chk("gate", 32'h1, {31'h0, intervalGate});
        for (int i = 0; i < 6; i++) begin
            chk("mux", {24'h0, entry[i % 3]}, {24'h0, muxSelect});
            pulse(0);
        end
        chk("convs", 32'h6, convs);
        pulse(0);
        chk("convs", 32'h6, convs);
        chk("gate", 32'h0, {31'h0, intervalGate});
        rd(`SASQ_REG_STATUS, 32'h2F, 32'h27, `SASQ_RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            rd(`SASQ_REG_FIFO, 32'hFFFF, 32'hA000 + i, `SASQ_RESP_OKAY);
        end
        rd(`SASQ_REG_STATUS, 32'h1, 32'h0, `SASQ_RESP_OKAY);
        // External strobes, count of two, no scanning
        wr(`SASQ_REG_CTRL, 32'h0, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_CNTLO, 32'h2, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_CLEAR, 32'h0, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_SCANLD, 32'h0, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_CTRL, 32'h29, `SASQ_RESP_OKAY);
        pulse(1);
        chk("convs", 32'h6, convs);
        pulse(2);
        repeat (3) pulse(1);
        chk("convs", 32'h8, convs);
        chk("gate", 32'h0, {31'h0, intervalGate});
        // Cascaded count, divider steps, overrun
        wr(`SASQ_REG_CNTLO, 32'h2, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_CNTHI, 32'h2, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_CLEAR, 32'h0, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_CTRL, 32'h1F, `SASQ_RESP_OKAY);
        pulse(2);
        repeat (2) pulse(0);
        chk("mux", 32'h11, {24'h0, muxSelect});
        pulse(4);
        chk("mux", 32'h22, {24'h0, muxSelect});
        rd(`SASQ_REG_CNTLO, 32'hFFFF, 32'h0, `SASQ_RESP_OKAY);
        rd(`SASQ_REG_CNTHI, 32'hFFFF, 32'h1, `SASQ_RESP_OKAY);
        rd(`SASQ_REG_STATUS, 32'h8, 32'h8, `SASQ_RESP_OKAY);
        for (int j = 0; j < 2; j++) begin
            @(posedge clk_sys) pinN[0] <= 1'h0;
            repeat (2) @(posedge clk_sys);
            pinN[0] <= 1'h1;
        end
        repeat (8) @(posedge clk_sys);
        rd(`SASQ_REG_STATUS, 32'hA, 32'h0, `SASQ_RESP_OKAY);
        wr(`SASQ_REG_CLEAR, 32'h0, `SASQ_RESP_OKAY);
        rd(`SASQ_REG_STATUS, 32'h1A, 32'h12, `SASQ_RESP_OKAY);
        conclude();
    end
endmodule
